// [rtl/sep_pkg.sv]
// Constants, encodings and state types of the serial EEPROM programming block
package sep_pkg;
    localparam int          CLK_NS     = 100;
    localparam int          CS_LOW_NS  = 250;
    localparam int          CS_LOW_CYC = (CS_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int          WP_MS      = 10;
    localparam int          WP_CYC     = (WP_MS * 1000000) / CLK_NS;
    localparam int          AW         = 6;
    localparam int          DW         = 16;
    localparam int          JOB_W      = 2 + AW + DW;
    localparam int          FIFO_DEPTH = 8;
    localparam logic [4:0]  CMD_LAST   = 5'h07;
    localparam logic [4:0]  DATA_LAST  = 5'h0F;
    localparam logic [5:0]  ADDR_LAST  = 6'h3F;
    localparam logic [1:0]  OP_EXT     = 2'h0;
    localparam logic [1:0]  OP_WRITE   = 2'h1;
    localparam logic [1:0]  OP_READ    = 2'h2;
    localparam logic [1:0]  OP_ERASE   = 2'h3;
    localparam logic [1:0]  EXT_DIS    = 2'h0;
    localparam logic [1:0]  EXT_WRITE_ALL_CMD   = 2'h1;
    localparam logic [1:0]  EXT_ERASE_ALL_CMD   = 2'h2;
    localparam logic [1:0]  EXT_EN     = 2'h3;
    localparam logic [1:0]  JOB_WRITE  = 2'h0;
    localparam logic [1:0]  JOB_ERASE  = 2'h1;
    localparam logic [1:0]  JOB_ERASE_ALL_CMD   = 2'h2;
    localparam logic [1:0]  JOB_WRITE_ALL_CMD   = 2'h3;
    localparam logic [15:0] ERASED     = 16'hFFFF;
    localparam logic        PROG_EN_RST = 1'b0;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_CMD  = 5'h02,
        ST_DATA = 5'h04,
        ST_READ = 5'h08,
        ST_DONE = 5'h10
    } sep_shift_t;

    typedef enum logic [2:0] {
        E_IDLE = 3'h1,
        E_FILL = 3'h2,
        E_WAIT = 3'h4
    } sep_eng_t;
endpackage

// [rtl/sep_fifo_if.sv]
// Valid/ready carrier between the command shifter, FIFO and engine
`timescale 1ns/1ps
`default_nettype none
interface sep_fifo_if #(parameter int W = 24);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// [rtl/sep_fifo.sv]
// Synchronous FIFO of programming jobs
`timescale 1ns/1ps
`default_nettype none
module sep_fifo #(
    parameter int W = 24,
    parameter int D = 8
) (
    input  wire logic   clk,
    input  wire logic   rst_n,
    sep_fifo_if.snk     wr_if,
    sep_fifo_if.src     rd_if
);
    localparam int PW = $clog2(D);

    logic [W-1:0] mem_r [D];
    logic [PW-1:0] wp_r;
    logic [PW-1:0] rp_r;
    logic [PW:0]   cnt_r;
    logic          do_wr;
    logic          do_rd;

    assign wr_if.ready = (cnt_r != (PW+1)'(D));
    assign rd_if.valid = (cnt_r != '0);
    assign rd_if.data  = mem_r[rp_r];
    assign do_wr       = wr_if.valid && wr_if.ready;
    assign do_rd       = rd_if.valid && rd_if.ready;

    always_ff @(posedge clk)
    begin
        if (do_wr)
        begin
            mem_r[wp_r] <= wr_if.data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end
        else
        begin
            if (do_wr)
            begin
                wp_r <= (wp_r == PW'(D - 1)) ? '0 : wp_r + 1'b1;
            end
            if (do_rd)
            begin
                rp_r <= (rp_r == PW'(D - 1)) ? '0 : rp_r + 1'b1;
            end
            if (do_wr && !do_rd)
            begin
                cnt_r <= cnt_r + 1'b1;
            end
            else if (do_rd && !do_wr)
            begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// [rtl/sep_top.sv]
// Three-wire serial EEPROM core: command shifter, programming engine, status
//
// Behaviour
// - Write takes 16 data bits; programming starts after the last one.
// - First select high after a programming command, once low at least 250 ns, shows ready/busy on output.
// - Status reads low while programming runs, high once finished.
// - Select raised after programming has ended gives no status.
// - Erase-all sets every bit to one; status as for a write.
// - Write-all stores one 16-bit pattern in every word; status likewise.
// - Programming disable blocks every erase and write until re-enabled.
// - Reads work whatever the enable state, in every frame that does not show status.
// - Command: select rises, start bit one, two-bit opcode, six address bits.
// - Write is 01, read 10, erase 11; opcode 00 with address 10, 01, 00, 11 for erase-all, write-all, disable, enable.
// - After reset programming is disabled until an enable command.
`timescale 1ns/1ps
`default_nettype none
module sep_top #(
    parameter int WP_CYCLES = sep_pkg::WP_CYC
) (
    input  wire logic CLK,
    input  wire logic RESET_N,
    input  wire logic CHIP_SELECT,
    input  wire logic SHIFT_CLOCK,
    input  wire logic SERIAL_IN,
    output var  logic SERIAL_OUT,
    output var  logic SERIAL_OUT_OE_N
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edges
    logic cs_s1_r, cs_s2_r, cs_d_r;
    logic sk_s1_r, sk_s2_r, sk_d_r;
    logic di_s1_r, di_s2_r;
    logic cs_rise, cs_fall, sk_rise;

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            {cs_s1_r, cs_s2_r, cs_d_r} <= 3'h0;
            {sk_s1_r, sk_s2_r, sk_d_r} <= 3'h0;
            {di_s1_r, di_s2_r}         <= 2'h0;
        end
        else
        begin
            {cs_s1_r, cs_s2_r, cs_d_r} <= {CHIP_SELECT, cs_s1_r, cs_s2_r};
            {sk_s1_r, sk_s2_r, sk_d_r} <= {SHIFT_CLOCK, sk_s1_r, sk_s2_r};
            {di_s1_r, di_s2_r}         <= {SERIAL_IN, di_s1_r};
        end
    end

    assign cs_rise = cs_s2_r && !cs_d_r;
    assign cs_fall = !cs_s2_r && cs_d_r;
    assign sk_rise = sk_s2_r && !sk_d_r;

    ////////////////////////////////////////////////////////////////////////
    // Job FIFO between shifter and engine
    sep_fifo_if #(.W(sep_pkg::JOB_W)) push_if ();
    sep_fifo_if #(.W(sep_pkg::JOB_W)) pop_if ();

    sep_fifo #(
        .W (sep_pkg::JOB_W),
        .D (sep_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk   (CLK),
        .rst_n (RESET_N),
        .wr_if (push_if),
        .rd_if (pop_if)
    );

    function automatic logic [sep_pkg::JOB_W-1:0] job_f(
        input logic [1:0]  kind,
        input logic [5:0]  addr,
        input logic [15:0] data
    );
        job_f = {kind, addr, data};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Command shifter
    sep_pkg::sep_shift_t        st_r;
    logic [4:0]                 cnt_r;
    logic [7:0]                 cmd_r;
    logic [15:0]                dat_r;
    logic [15:0]                rd_sh_r;
    logic                       rd_bit_r;
    logic                       prog_en_r;
    logic                       push_r;
    logic [sep_pkg::JOB_W-1:0]  job_r;
    logic [7:0]                 cmd_nxt;
    logic [15:0]                dat_nxt;
    logic [15:0]                mem_r [64];

    assign cmd_nxt       = {cmd_r[6:0], di_s2_r};
    assign dat_nxt       = {dat_r[14:0], di_s2_r};
    assign push_if.valid = push_r;
    assign push_if.data  = job_r;

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            st_r      <= sep_pkg::ST_IDLE;
            cnt_r     <= 5'h00;
            cmd_r     <= 8'h00;
            dat_r     <= 16'h0000;
            rd_sh_r   <= 16'h0000;
            rd_bit_r  <= 1'b0;
            prog_en_r <= sep_pkg::PROG_EN_RST;
            push_r    <= 1'b0;
            job_r     <= '0;
        end
        else
        begin
            if (push_r && push_if.ready)
            begin
                push_r <= 1'b0;
            end
            if (cs_fall)
            begin
                st_r <= sep_pkg::ST_IDLE;
            end
            else if (cs_s2_r && sk_rise)
            begin
                case (st_r)
                    sep_pkg::ST_IDLE:
                    begin
                        if (di_s2_r)
                        begin
                            st_r  <= sep_pkg::ST_CMD;
                            cnt_r <= 5'h00;
                        end
                    end
                    sep_pkg::ST_CMD:
                    begin
                        cmd_r <= cmd_nxt;
                        cnt_r <= cnt_r + 5'h01;
                        if (cnt_r == sep_pkg::CMD_LAST)
                        begin
                            st_r  <= sep_pkg::ST_DONE;
                            cnt_r <= 5'h00;
                            case (cmd_nxt[7:6])
                                sep_pkg::OP_READ:
                                begin
                                    st_r     <= sep_pkg::ST_READ;
                                    rd_sh_r  <= mem_r[cmd_nxt[5:0]];
                                    rd_bit_r <= 1'b0;
                                end
                                sep_pkg::OP_WRITE:
                                begin
                                    st_r <= sep_pkg::ST_DATA;
                                end
                                sep_pkg::OP_ERASE:
                                begin
                                    push_r <= prog_en_r;
                                    job_r  <= job_f(sep_pkg::JOB_ERASE,
                                                    cmd_nxt[5:0],
                                                    sep_pkg::ERASED);
                                end
                                default:
                                begin
                                    case (cmd_nxt[5:4])
                                        sep_pkg::EXT_EN:
                                        begin
                                            prog_en_r <= 1'b1;
                                        end
                                        sep_pkg::EXT_DIS:
                                        begin
                                            prog_en_r <= 1'b0;
                                        end
                                        sep_pkg::EXT_ERASE_ALL_CMD:
                                        begin
                                            push_r <= prog_en_r;
                                            job_r  <= job_f(sep_pkg::JOB_ERASE_ALL_CMD,
                                                            6'h00,
                                                            sep_pkg::ERASED);
                                        end
                                        default:
                                        begin
                                            st_r <= sep_pkg::ST_DATA;
                                        end
                                    endcase
                                end
                            endcase
                        end
                    end
                    sep_pkg::ST_DATA:
                    begin
                        dat_r <= dat_nxt;
                        cnt_r <= cnt_r + 5'h01;
                        if (cnt_r == sep_pkg::DATA_LAST)
                        begin
                            st_r   <= sep_pkg::ST_DONE;
                            push_r <= prog_en_r;
                            job_r  <= job_f((cmd_r[7:6] == sep_pkg::OP_WRITE)
                                            ? sep_pkg::JOB_WRITE
                                            : sep_pkg::JOB_WRITE_ALL_CMD,
                                            cmd_r[5:0], dat_nxt);
                        end
                    end
                    sep_pkg::ST_READ:
                    begin
                        rd_bit_r <= rd_sh_r[15];
                        rd_sh_r  <= {rd_sh_r[14:0], 1'b0};
                    end
                    default:
                    begin
                        st_r <= st_r;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Programming engine
    sep_pkg::sep_eng_t eng_r;
    logic [5:0]        ea_r;
    logic [15:0]       ed_r;
    logic [23:0]       wcnt_r;
    logic              busy;
    logic              job_all_r;

    assign pop_if.ready = (eng_r == sep_pkg::E_IDLE);
    assign busy = (eng_r != sep_pkg::E_IDLE) || pop_if.valid || push_r;

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            eng_r  <= sep_pkg::E_IDLE;
            ea_r   <= 6'h00;
            ed_r   <= 16'h0000;
            wcnt_r <= 24'h000000;
        end
        else
        begin
            case (eng_r)
                sep_pkg::E_IDLE:
                begin
                    wcnt_r <= 24'h000000;
                    if (pop_if.valid)
                    begin
                        ea_r <= pop_if.data[21:16];
                        ed_r <= pop_if.data[15:0];
                        if (pop_if.data[23])
                        begin
                            eng_r <= sep_pkg::E_FILL;
                            ea_r  <= 6'h00;
                        end
                        else
                        begin
                            eng_r <= sep_pkg::E_FILL;
                        end
                    end
                end
                sep_pkg::E_FILL:
                begin
                    mem_r[ea_r] <= ed_r;
                    ea_r        <= ea_r + 6'h01;
                    if (ea_r == sep_pkg::ADDR_LAST || !job_all_r)
                    begin
                        eng_r <= sep_pkg::E_WAIT;
                    end
                end
                sep_pkg::E_WAIT:
                begin
                    wcnt_r <= wcnt_r + 24'h000001;
                    if (wcnt_r == 24'(WP_CYCLES - 1))
                    begin
                        eng_r <= sep_pkg::E_IDLE;
                    end
                end
                default:
                begin
                    eng_r <= sep_pkg::E_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            job_all_r <= 1'b0;
        end
        else if (eng_r == sep_pkg::E_IDLE && pop_if.valid)
        begin
            job_all_r <= pop_if.data[23];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ready/busy status and output pin
    logic [1:0] cs_low_r;
    logic       arm_r;
    logic       status_r;

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            cs_low_r <= 2'h0;
            arm_r    <= 1'b0;
            status_r <= 1'b0;
        end
        else
        begin
            if (cs_s2_r)
            begin
                cs_low_r <= 2'h0;
            end
            else if (cs_low_r != 2'(sep_pkg::CS_LOW_CYC))
            begin
                cs_low_r <= cs_low_r + 2'h1;
            end
            if (cs_rise)
            begin
                status_r <= arm_r && busy &&
                            (cs_low_r == 2'(sep_pkg::CS_LOW_CYC));
            end
            else if (cs_fall)
            begin
                status_r <= 1'b0;
            end
            if (push_r && push_if.ready)
            begin
                arm_r <= 1'b1;
            end
            else if (cs_rise)
            begin
                arm_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            SERIAL_OUT      <= 1'b0;
            SERIAL_OUT_OE_N <= 1'b1;
        end
        else
        begin
            SERIAL_OUT      <= status_r ? !busy : rd_bit_r;
            SERIAL_OUT_OE_N <= !(status_r || st_r == sep_pkg::ST_READ);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    a_write_after_data: assert property (
        $rose(push_r) && job_r[23:22] == sep_pkg::JOB_WRITE
        |-> $past(st_r) == sep_pkg::ST_DATA
            && $past(cnt_r) == sep_pkg::DATA_LAST)
        else $error("write job before sixteenth data bit");
    a_status_drives_pin: assert property (
        status_r |=> !SERIAL_OUT_OE_N)
        else $error("status shown with pin released");
    a_status_busy_low: assert property (
        status_r && busy |=> !SERIAL_OUT)
        else $error("status high while busy");
    a_status_ready_high: assert property (
        status_r && !busy |=> SERIAL_OUT)
        else $error("status low while ready");
    a_late_no_status: assert property (
        cs_rise && !busy |=> !status_r ##1 SERIAL_OUT_OE_N)
        else $error("status given after programming ended");
    a_erase_all_cmd_all_ones: assert property (
        push_r && job_r[23:22] == sep_pkg::JOB_ERASE_ALL_CMD
        |-> job_r[15:0] == sep_pkg::ERASED)
        else $error("erase-all pattern not all ones");
    a_fill_pattern: assert property (
        eng_r == sep_pkg::E_FILL && job_all_r
        |=> mem_r[$past(ea_r)] == $past(ed_r))
        else $error("write-all word not stored");
    a_push_enabled: assert property (
        $rose(push_r) |-> $past(prog_en_r))
        else $error("programming while disabled");
    a_read_free: assert property (
        st_r == sep_pkg::ST_CMD && cs_s2_r && sk_rise && !cs_fall
        && cnt_r == sep_pkg::CMD_LAST && cmd_nxt[7:6] == sep_pkg::OP_READ
        |=> st_r == sep_pkg::ST_READ ##1 !SERIAL_OUT_OE_N)
        else $error("read not started");
    a_start_bit: assert property (
        st_r == sep_pkg::ST_IDLE && cs_s2_r && sk_rise && !di_s2_r
        |=> st_r == sep_pkg::ST_IDLE)
        else $error("command began without start bit");

    c_write_job: cover property (
        $rose(push_r) && job_r[23:22] == sep_pkg::JOB_WRITE);
    c_erase_all_cmd_job: cover property (
        $rose(push_r) && job_r[23:22] == sep_pkg::JOB_ERASE_ALL_CMD);
    c_read: cover property (st_r == sep_pkg::ST_READ && sk_rise);
    c_ready_seen: cover property (status_r && !busy);
endmodule
`default_nettype wire

// [testbench/sep_host_model.sv]
// Host controller model driving select, shift clock and serial data
`timescale 1ns/1ps
`default_nettype none
module sep_host_model (
    input  wire logic clk,
    input  wire logic do_pin,
    input  wire logic do_oe_n,
    output var  logic cs,
    output var  logic sk,
    output var  logic si
);
    logic last_q = 1'b0;

    initial
    begin
        cs = 1'b0;
        sk = 1'b0;
        si = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One shift clock of 8 CLK; DI set up 2 CLK before the rise
    task automatic bit_cycle(input logic b, output logic q);
        si <= b;
        repeat (2) @(posedge clk);
        sk <= 1'b1;
        repeat (4) @(posedge clk);
        sk <= 1'b0;
        repeat (2) @(posedge clk);
        q = (do_oe_n === 1'b0) ? do_pin : ~last_q;
        last_q = q;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Whole frames only
    task automatic frame(input logic [24:0] w, input int n, input int nrd,
                         output logic [16:0] rd);
        logic q;
        cs <= 1'b1;
        repeat (2) @(posedge clk);
        for (int i = n - 1; i >= 0; i--)
            bit_cycle(w[i], q);
        rd = {16'h0000, q};
        for (int i = 1; i < nrd; i++)
        begin
            bit_cycle(~si, q);
            rd = {rd[15:0], q};
        end
        cs <= 1'b0;
        si <= ~si;
        repeat (5) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Poll until ready
    task automatic poll(output logic oe0, output logic do0, output logic rdy);
        cs <= 1'b1;
        repeat (8) @(posedge clk);
        oe0 = do_oe_n;
        do0 = do_pin;
        rdy = 1'b0;
        for (int k = 0; k < 400 && rdy !== 1'b1; k++)
        begin
            @(posedge clk);
            rdy = (do_oe_n === 1'b0) && (do_pin === 1'b1);
        end
        cs <= 1'b0;
        repeat (5) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// [testbench/serial_eeprom_program_cmds_bench.sv]
// Self-checking bench of the serial EEPROM programming block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
    begin \
        checks_done++; \
        if ((g) !== (e)) \
        begin \
            n_mismatch++; \
            $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
        end \
    end
module serial_eeprom_program_cmds_bench;
    localparam int WPC   = 50;
    localparam int LIMIT = 40000;
    logic          clk = 1'b0;
    logic          reset_n = 1'b0;
    wire logic     cs;
    wire logic     sk;
    wire logic     si;
    wire logic     so;
    wire logic     so_oe_n;
    int            n_mismatch = 0;
    int            checks_done = 0;
    int            cycles = 0;
    int            seed = 32'h6c5a;
    int            mem_m [64];
    logic          en_m = 1'b0;
    logic          oe0;
    logic          do0;
    logic          rdy;
    logic [16:0]   rd;
    logic [5:0]    a;
    logic [15:0]   d;

    always #50 clk = ~clk;

    sep_top #(.WP_CYCLES(WPC)) u_dut (
        .CLK             (clk),
        .RESET_N         (reset_n),
        .CHIP_SELECT     (cs),
        .SHIFT_CLOCK     (sk),
        .SERIAL_IN       (si),
        .SERIAL_OUT      (so),
        .SERIAL_OUT_OE_N (so_oe_n)
    );

    sep_host_model u_host (
        .clk     (clk),
        .do_pin  (so),
        .do_oe_n (so_oe_n),
        .cs      (cs),
        .sk      (sk),
        .si      (si)
    );

    ////////////////////////////////////////////////////////////////////////
    // Verdict and hang guard
    task automatic tally_and_finish();
        if (n_mismatch == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command helpers
    function automatic logic [24:0] ext(input logic [1:0] c);
        ext = {16'h0000, 1'b1, sep_pkg::OP_EXT, c, 4'($random(seed))};
    endfunction

    task automatic prog(input logic [24:0] w, input int n);
        u_host.frame(w, n, 0, rd);
        u_host.poll(oe0, do0, rdy);
        if (en_m)
        begin
            `CHK(oe0, 1'b0)
            `CHK(do0, 1'b0)
            `CHK(rdy, 1'b1)
        end
        else
            `CHK(oe0, 1'b1)
    endtask

    task automatic wr(input logic [5:0] aa, input logic [15:0] dd);
        prog({1'b1, sep_pkg::OP_WRITE, aa, dd}, 25);
        if (en_m)
            mem_m[aa] = dd;
    endtask

    task automatic rd_chk(input logic [5:0] aa);
        u_host.frame({16'h0000, 1'b1, sep_pkg::OP_READ, aa}, 9, 17, rd);
        `CHK(rd, {1'b0, 16'(mem_m[aa])})
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        wr(6'h05, 16'h1234);
        u_host.frame(ext(sep_pkg::EXT_EN), 9, 0, rd);
        en_m = 1'b1;
        prog(ext(sep_pkg::EXT_ERASE_ALL_CMD), 9);
        foreach (mem_m[i])
            mem_m[i] = 16'hFFFF;
        rd_chk(6'h00);
        rd_chk(6'h3F);
        for (int i = 0; i < 4; i++)
        begin
            a = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : 6'($random(seed));
            d = 16'($random(seed));
            wr(a, d);
            rd_chk(a);
        end
        prog({16'h0000, 1'b1, sep_pkg::OP_ERASE, a}, 9);
        mem_m[a] = 16'hFFFF;
        rd_chk(a);
        d = 16'($random(seed));
        prog({1'b1, sep_pkg::OP_EXT, sep_pkg::EXT_WRITE_ALL_CMD, 4'hA, d}, 25);
        foreach (mem_m[i])
            mem_m[i] = d;
        rd_chk(6'($random(seed)));
        rd_chk(6'($random(seed)));
        a = 6'($random(seed));
        d = 16'($random(seed));
        u_host.frame({1'b1, sep_pkg::OP_WRITE, a, d}, 25, 0, rd);
        mem_m[a] = d;
        repeat (WPC + 40) @(posedge clk);
        u_host.poll(oe0, do0, rdy);
        `CHK(oe0, 1'b1)
        `CHK(rdy, 1'b0)
        rd_chk(a);
        u_host.frame(ext(sep_pkg::EXT_DIS), 9, 0, rd);
        en_m = 1'b0;
        wr(a, ~d);
        prog(ext(sep_pkg::EXT_ERASE_ALL_CMD), 9);
        rd_chk(a);
        tally_and_finish();
    end
endmodule
`default_nettype wire
